// ### rtl/onoff_pkg.sv
// constants and carrier types for the power switch configuration block
package onoff_pkg;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ONOFF = 8'h02;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_GUARD = 8'h10;
  localparam logic [7:0] CMD_STORE = 8'h11;
  localparam logic [7:0] CMD_VOUT = 8'h21;
  localparam int BIT_GATE = 4;
  localparam int BIT_OBEY = 3;
  localparam int BIT_PINRESP = 2;
  localparam int BIT_SENSE = 1;
  localparam int BIT_OFFSTYLE = 0;
  localparam logic [4:0] ONOFF_RST = 5'h16;
  localparam logic [7:0] GUARD_RST = 8'h00;
  localparam logic [7:0] GUARD_MASK = 8'hE0;
  localparam logic [7:0] GUARD_ALL = 8'h80;
  localparam logic [7:0] GUARD_OPER = 8'h40;
  localparam logic [7:0] GUARD_CFG = 8'h20;
  localparam int CLK_MHZ = 20;
  localparam int PIN_LOW_NS = 100;
  // strictly longer than the minimum, so one cycle above the truncated count
  localparam logic [3:0] PIN_LOW_CYC = 4'((PIN_LOW_NS * CLK_MHZ) / 1000 + 1);

  typedef struct packed {
    logic [7:0] code;
    logic wr;
    logic [7:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic nack;
    logic [7:0] data;
  } cmd_rsp_t;

  typedef struct packed {
    logic [4:0] onoff;
    logic [7:0] guard;
  } nvm_img_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'h0,
    L_WAIT = 2'h1,
    L_DONE = 2'h3
  } link_state_t;
endpackage

// ### rtl/power_switch_ctrl.sv
// on/off configuration, clear-faults, low-side latch and write guard
`timescale 1ns/1ps
`default_nettype none
module power_switch_ctrl #(
  parameter int NFLT = 4
) (
  // clocks, reset, enable
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  // command link, link clock domain
  input wire logic req_valid_i,
  input wire onoff_pkg::cmd_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output onoff_pkg::cmd_rsp_t rsp_o,
  // pins and analog comparators
  input wire logic enable_pin_i,
  input wire logic feedback_low_i,
  // device-side inputs, core clock
  input wire logic loop_slave_i,
  input wire logic sense_nvm_i,
  input wire logic vin_ok_i,
  input wire logic on_bit_i,
  input wire logic soft_cmd_i,
  input wire logic ov_latch_i,
  input wire logic release_select_i,
  input wire logic [NFLT-1:0] faults_i,
  input wire logic restore_i,
  input wire onoff_pkg::nvm_img_t restore_img_i,
  // converter control and status
  output logic run_o,
  output logic soft_off_o,
  output logic low_switch_o,
  output logic alert_o,
  output logic [NFLT+1:0] status_o,
  output logic store_o,
  output onoff_pkg::nvm_img_t store_img_o,
  output logic [4:0] config_o
);
  localparam int ST_IVC = NFLT;
  localparam int ST_CML = NFLT + 1;

  if (NFLT < 1 || NFLT > 16) begin : g_chk
    $error("NFLT must be 1 to 16");
  end

  typedef struct packed {
    onoff_pkg::link_state_t st;
    logic ready;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    onoff_pkg::cmd_req_t req;
    logic rsp_valid;
    onoff_pkg::cmd_rsp_t rsp;
  } link_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    onoff_pkg::cmd_rsp_t rsp;
    logic pin_s1;
    logic pin_s2;
    logic fbk_s1;
    logic fbk_s2;
    logic [3:0] low_cnt;
    logic [4:0] onoff;
    logic [7:0] guard;
    logic sense_act;
    logic sense_loaded;
    logic [NFLT+1:0] status;
    logic alert;
    logic latched;
    logic low_sw;
    logic run;
    logic soft_off;
    logic store;
  } core_t;

  link_t lq;
  link_t ld;
  core_t cq;
  core_t cd;

  function automatic logic write_ok(input logic [7:0] g, input logic [7:0] c);
    logic ok;
    ok = 1'b1;
    case (g & onoff_pkg::GUARD_MASK)
      onoff_pkg::GUARD_ALL: ok = (c == onoff_pkg::CMD_GUARD);
      onoff_pkg::GUARD_OPER: ok = (c == onoff_pkg::CMD_GUARD) || (c == onoff_pkg::CMD_OPERATION);
      onoff_pkg::GUARD_CFG: ok = (c == onoff_pkg::CMD_GUARD) || (c == onoff_pkg::CMD_OPERATION)
                              || (c == onoff_pkg::CMD_ONOFF) || (c == onoff_pkg::CMD_VOUT);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // link side: one request in flight, handed over by toggle
  always_comb begin
    ld = lq;
    ld.ack_s1 = cq.ack_tgl;
    ld.ack_s2 = lq.ack_s1;
    ld.rsp_valid = 1'b0;
    case (lq.st)
      onoff_pkg::L_IDLE: begin
        if (req_valid_i) begin
          ld.req = req_i;
          ld.req_tgl = ~lq.req_tgl;
          ld.st = onoff_pkg::L_WAIT;
        end
      end
      onoff_pkg::L_WAIT: begin
        if (lq.ack_s2 != lq.ack_seen) begin
          ld.ack_seen = lq.ack_s2;
          // core answer is frozen until the next toggle, safe to sample
          ld.rsp = cq.rsp;
          ld.rsp_valid = 1'b1;
          ld.st = onoff_pkg::L_DONE;
        end
      end
      onoff_pkg::L_DONE: ld.st = onoff_pkg::L_IDLE;
      default: ld.st = onoff_pkg::L_IDLE;
    endcase
    // registered so the ready output comes straight from a flop
    ld.ready = (ld.st == onoff_pkg::L_IDLE);
  end

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lq <= '0;
      lq.ready <= 1'b1;
    end else begin
      lq <= ld;
    end
  end

  assign req_ready_o = lq.ready;
  assign rsp_valid_o = lq.rsp_valid;
  assign rsp_o = lq.rsp;

  // core side
  logic req_new;
  logic pin_active;
  logic pin_clear;
  logic clr_all;
  logic [NFLT+1:0] sets;
  logic run_req;
  logic pin_cause;

  always_comb begin
    cd = cq;
    sets = '0;
    clr_all = 1'b0;
    cd.req_s1 = lq.req_tgl;
    cd.req_s2 = cq.req_s1;
    cd.pin_s1 = enable_pin_i;
    cd.pin_s2 = cq.pin_s1;
    cd.fbk_s1 = feedback_low_i;
    cd.fbk_s2 = cq.fbk_s1;
    cd.store = 1'b0;
    // polarity in use only follows the stored copy once per power-up
    if (!cq.sense_loaded) begin
      cd.sense_act = sense_nvm_i;
      cd.sense_loaded = 1'b1;
    end
    pin_active = (cq.pin_s2 == cq.sense_act);
    if (cq.pin_s2) begin
      cd.low_cnt = '0;
    end else if (cq.low_cnt != onoff_pkg::PIN_LOW_CYC) begin
      cd.low_cnt = cq.low_cnt + 4'h1;
    end
    pin_clear = cq.pin_s2 && (cq.low_cnt == onoff_pkg::PIN_LOW_CYC);
    if (restore_i) begin
      if (write_ok(cq.guard, onoff_pkg::CMD_ONOFF)) begin
        cd.onoff = restore_img_i.onoff;
      end
      cd.guard = restore_img_i.guard;
    end
    req_new = (cq.req_s2 != cq.req_seen);
    if (req_new) begin
      cd.req_seen = cq.req_s2;
      cd.ack_tgl = ~cq.ack_tgl;
      cd.rsp = '0;
      case (lq.req.code)
        onoff_pkg::CMD_ONOFF: begin
          if (loop_slave_i) begin
            cd.rsp.nack = 1'b1;
            sets[ST_IVC] = 1'b1;
          end else if (!lq.req.wr) begin
            cd.rsp.data = {3'h0, cq.onoff};
          end else if (write_ok(cq.guard, onoff_pkg::CMD_ONOFF)) begin
            cd.onoff = lq.req.data[4:0];
          end else begin
            cd.rsp.nack = 1'b1;
            sets[ST_CML] = 1'b1;
          end
        end
        onoff_pkg::CMD_GUARD: begin
          if (!lq.req.wr) begin
            cd.rsp.data = cq.guard;
          end else begin
            cd.guard = lq.req.data;
            // an invalid value stays readable but protects nothing
            sets[ST_CML] = (lq.req.data[7] & lq.req.data[6]) | (lq.req.data[7] & lq.req.data[5])
                         | (lq.req.data[6] & lq.req.data[5]);
          end
        end
        onoff_pkg::CMD_CLEAR, onoff_pkg::CMD_STORE: begin
          if (!lq.req.wr) begin
            cd.rsp.nack = 1'b1;
            sets[ST_IVC] = 1'b1;
          end else if (!write_ok(cq.guard, lq.req.code)) begin
            cd.rsp.nack = 1'b1;
            sets[ST_CML] = 1'b1;
          end else if (lq.req.code == onoff_pkg::CMD_CLEAR) begin
            clr_all = 1'b1;
          end else begin
            cd.store = 1'b1;
          end
        end
        default: begin
          cd.rsp.nack = 1'b1;
          sets[ST_IVC] = 1'b1;
        end
      endcase
    end
    clr_all = clr_all | pin_clear;
    sets[NFLT-1:0] = faults_i;
    // set beats clear, so a fault still present reappears at once
    cd.status = (clr_all ? '0 : cq.status) | sets;
    cd.alert = |cd.status;
    // overvoltage latch of the low-side switch
    if (ov_latch_i) begin
      cd.low_sw = 1'b1;
    end else if (release_select_i ? cq.fbk_s2 : clr_all) begin
      cd.low_sw = 1'b0;
    end
    // start decision
    if (!cq.onoff[onoff_pkg::BIT_GATE]) begin
      run_req = 1'b1;
    end else begin
      run_req = (!cq.onoff[onoff_pkg::BIT_PINRESP] || pin_active)
              && (!cq.onoff[onoff_pkg::BIT_OBEY] || on_bit_i);
    end
    // a latch clears only when the start request is withdrawn, not on clear
    if (ov_latch_i) begin
      cd.latched = 1'b1;
    end else if (!run_req) begin
      cd.latched = 1'b0;
    end
    cd.run = run_req && vin_ok_i && !(|faults_i) && !cq.latched;
    pin_cause = cq.onoff[onoff_pkg::BIT_GATE] && cq.onoff[onoff_pkg::BIT_PINRESP] && !pin_active;
    cd.soft_off = pin_cause ? !cq.onoff[onoff_pkg::BIT_OFFSTYLE] : soft_cmd_i;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cq <= '0;
      cq.onoff <= onoff_pkg::ONOFF_RST;
      cq.guard <= onoff_pkg::GUARD_RST;
      cq.sense_act <= 1'b1;
      cq.soft_off <= 1'b1;
    end else if (ce_i) begin
      cq <= cd;
    end
  end

  assign run_o = cq.run;
  assign soft_off_o = cq.soft_off;
  assign low_switch_o = cq.low_sw;
  assign alert_o = cq.alert;
  assign status_o = cq.status;
  assign store_o = cq.store;
  assign store_img_o = '{onoff: cq.onoff, guard: cq.guard};
  assign config_o = cq.onoff;

  AST_FREE_RUN: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && !cq.onoff[onoff_pkg::BIT_GATE] && vin_ok_i && !(|faults_i) && !cq.latched
    |=> run_o) else $error("converter not running with gate bit clear");
  AST_LOW_SET: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && ov_latch_i |=> low_switch_o ##1 (low_switch_o || !ce_i || !ov_latch_i))
    else $error("low switch not latched on overvoltage");
  AST_LOW_HOLD: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && low_switch_o && !release_select_i && !clr_all |=> low_switch_o)
    else $error("low switch dropped without clear");
  AST_CLEAR_ALL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && clr_all && (sets == '0) |=> (status_o == '0) && !alert_o)
    else $error("status or alert left after clear");
  AST_REFIRE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && faults_i[0] |=> status_o[0] && alert_o)
    else $error("persisting fault not reported");
  AST_NO_RESTART: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && cq.latched |=> !run_o) else $error("latched converter restarted");
  AST_SLAVE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && req_new && loop_slave_i && (lq.req.code == onoff_pkg::CMD_ONOFF)
    |=> cq.rsp.nack && status_o[ST_IVC] && alert_o) else $error("slave access not refused");
  AST_GUARDED: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && ((cq.guard & onoff_pkg::GUARD_MASK) == onoff_pkg::GUARD_ALL)
    && !(req_new && lq.req.code == onoff_pkg::CMD_GUARD && lq.req.wr)
    |=> $stable(config_o)) else $error("guarded config changed");
  AST_SENSE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    cq.sense_loaded |=> $stable(cq.sense_act)) else $error("pin polarity changed at run time");

  // start selection, status, low switch, guard, store and link checks
  AST_ALERT_OR: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    alert_o == (|status_o)) else $error("alert does not follow status");
  AST_GATED_OFF: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && cq.onoff[onoff_pkg::BIT_GATE] && cq.onoff[onoff_pkg::BIT_PINRESP] && !pin_active
    |=> !run_o) else $error("converter running with pin inactive");
  AST_OBEY: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && cq.onoff[onoff_pkg::BIT_GATE] && cq.onoff[onoff_pkg::BIT_OBEY] && !on_bit_i
    |=> !run_o) else $error("converter running with serial on clear");
  AST_PIN_IGNORED: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && cq.onoff[onoff_pkg::BIT_GATE] && !cq.onoff[onoff_pkg::BIT_PINRESP]
    && !cq.onoff[onoff_pkg::BIT_OBEY] && vin_ok_i && !(|faults_i) && !cq.latched
    |=> run_o) else $error("converter stopped with pin ignored");
  AST_VIN: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && !vin_ok_i |=> !run_o) else $error("converter running below lockout");
  AST_OFF_STYLE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && pin_cause && cq.onoff[onoff_pkg::BIT_OFFSTYLE] |=> !soft_off_o)
    else $error("immediate off not selected");
  AST_LOW_CLEAR: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && clr_all && !release_select_i && !ov_latch_i |=> !low_switch_o)
    else $error("low switch kept after clear");
  AST_STORE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && req_new && lq.req.wr && (lq.req.code == onoff_pkg::CMD_STORE)
    && ((cq.guard & onoff_pkg::GUARD_MASK) == 8'h00) |=> store_o) else $error("store not issued");
  AST_BAD_GUARD: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && req_new && lq.req.wr && (lq.req.code == onoff_pkg::CMD_GUARD) && (lq.req.data == 8'hE0)
    |=> status_o[ST_CML] && alert_o) else $error("invalid guard value not flagged");
  AST_GUARD_BLOCK: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && req_new && lq.req.wr && !loop_slave_i && (lq.req.code == onoff_pkg::CMD_ONOFF)
    && ((cq.guard & onoff_pkg::GUARD_MASK) == onoff_pkg::GUARD_ALL)
    |=> cq.rsp.nack && status_o[ST_CML]) else $error("guarded write not refused");
  AST_CFG_READ: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && req_new && !lq.req.wr && !loop_slave_i && (lq.req.code == onoff_pkg::CMD_ONOFF)
    |=> !cq.rsp.nack && (cq.rsp.data[7:5] == 3'h0)) else $error("config read refused");
  AST_GUARD_READ: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && req_new && !lq.req.wr && (lq.req.code == onoff_pkg::CMD_GUARD)
    |=> !cq.rsp.nack && (cq.rsp.data == $past(cq.guard))) else $error("guard read refused");
  AST_RSP_ONE: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    rsp_valid_o |=> !rsp_valid_o) else $error("answer strobe longer than one cycle");
endmodule // power_switch_ctrl
`default_nettype wire

// ### verif/host_link_model.sv
// host-side command link master for single-byte transfers
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // link side
  input wire logic link_clk_i,
  output logic req_valid_o,
  output onoff_pkg::cmd_req_t req_o,
  input wire logic req_ready_i,
  input wire logic rsp_valid_i,
  input wire onoff_pkg::cmd_rsp_t rsp_i
);
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // one outstanding request, held until the taking edge
  task automatic xfer(input logic [7:0] code, input logic wr, input logic [7:0] data,
                      output onoff_pkg::cmd_rsp_t rsp);
    int n;
    n = 0;
    @(posedge link_clk_i);
    req_valid_o <= 1'b1;
    req_o <= '{code, wr, data};
    @(posedge link_clk_i);
    while (req_ready_i !== 1'b1 && n < 100) begin
      n++;
      @(posedge link_clk_i);
    end
    req_valid_o <= 1'b0;
    // released lines must not look like a held request
    req_o <= onoff_pkg::cmd_req_t'(~req_o);
    while (rsp_valid_i !== 1'b1 && n < 200) begin
      n++;
      @(posedge link_clk_i);
    end
    rsp = rsp_i;
    // a lost answer must never look like a good one
    if (n >= 200) rsp = 'x;
  endtask
endmodule // host_link_model
`default_nettype wire

// ### verif/power_switch_ctrl_tb.sv
// self-checking bench for the power switch configuration block
`timescale 1ns/1ps
`default_nettype none
module power_switch_ctrl_tb;
  logic mclk_i = 0, link_clk_i = 0, rstn_i = 0;
  logic req_valid, req_ready, rsp_valid, pin, fb_low, slave, vin_ok, on_bit;
  logic ov, rel, restore, run, soft_off, low_sw, alert, store;
  logic [3:0] flt;
  logic ce = 1'b1;
  logic [5:0] status;
  logic [4:0] cfg;
  logic [4:0] cfgs [5] = '{5'h00, 5'h10, 5'h18, 5'h14, 5'h1C};
  onoff_pkg::cmd_req_t req;
  onoff_pkg::cmd_rsp_t rsp, got;
  onoff_pkg::nvm_img_t img, simg;
  int fails = 0, n_compared = 0, stores = 0;
  always #25 mclk_i = ~mclk_i;
  always #3 link_clk_i = ~link_clk_i;
  always @(posedge mclk_i) if (store === 1'b1) stores++;
  host_link_model u_host_link_model (.link_clk_i(link_clk_i), .req_valid_o(req_valid),
    .req_o(req), .req_ready_i(req_ready), .rsp_valid_i(rsp_valid), .rsp_i(rsp));
  power_switch_ctrl u_power_switch_ctrl (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce),
    .link_clk_i(link_clk_i), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
    .rsp_valid_o(rsp_valid), .rsp_o(rsp), .enable_pin_i(pin), .feedback_low_i(fb_low),
    .loop_slave_i(slave), .sense_nvm_i(1'b1), .vin_ok_i(vin_ok), .on_bit_i(on_bit),
    .soft_cmd_i(1'b1), .ov_latch_i(ov), .release_select_i(rel), .faults_i(flt),
    .restore_i(restore), .restore_img_i(img), .run_o(run), .soft_off_o(soft_off),
    .low_switch_o(low_sw), .alert_o(alert), .status_o(status), .store_o(store),
    .store_img_o(simg), .config_o(cfg));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic nk);
    u_host_link_model.xfer(c, 1'b1, d, got);
    cyc(2);
    check(got.nack, nk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] d, input logic nk);
    u_host_link_model.xfer(c, 1'b0, 8'h00, got);
    cyc(2);
    check({got.nack, got.data}, {nk, d});
  endtask
  task automatic ov_pulse;
    ov = 1'b1;
    cyc(1);
    ov = 1'b0;
    cyc(3);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    give_verdict();
  end
  initial begin
    {fb_low, slave, on_bit, ov, rel, restore} = '0;
    {pin, vin_ok} = 2'b11;
    flt = 4'h0;
    img = '0;
    repeat (16) @(negedge mclk_i);
    rstn_i = 1'b1;
    cyc(6);
    check(cfg, onoff_pkg::ONOFF_RST);
    check({run, soft_off}, 2'b11);
    rd(onoff_pkg::CMD_ONOFF, 8'h16, 1'b0);
    rd(onoff_pkg::CMD_GUARD, 8'h00, 1'b0);
    // 14h carries sense 0: polarity must stay active high
    foreach (cfgs[i]) begin
      wr(onoff_pkg::CMD_ONOFF, {3'b111, cfgs[i]}, 1'b0);
      rd(onoff_pkg::CMD_ONOFF, {3'b000, cfgs[i]}, 1'b0);
      for (int k = 0; k < 4; k++) begin
        pin = k[0];
        on_bit = k[1];
        cyc(6);
        check(run, !cfgs[i][4] || ((!cfgs[i][3] || k[1]) && (!cfgs[i][2] || k[0])));
      end
    end
    vin_ok = 1'b0;
    cyc(4);
    check(run, 1'b0);
    vin_ok = 1'b1;
    flt = 4'h1;
    cyc(4);
    check(run, 1'b0);
    flt = 4'h0;
    for (int j = 0; j < 2; j++) begin
      wr(onoff_pkg::CMD_ONOFF, 8'h14 | j[7:0], 1'b0);
      pin = 1'b1;
      cyc(6);
      pin = 1'b0;
      cyc(6);
      check(soft_off, !j[0]);
    end
    pin = 1'b1;
    slave = 1'b1;
    cyc(2);
    wr(onoff_pkg::CMD_ONOFF, 8'h00, 1'b1);
    check({alert, status[4]}, 2'b11);
    slave = 1'b0;
    rd(onoff_pkg::CMD_ONOFF, 8'h15, 1'b0);
    wr(onoff_pkg::CMD_CLEAR, 8'h00, 1'b0);
    check({alert, status}, 7'h00);
    flt = 4'h3;
    cyc(4);
    flt = 4'h2;
    wr(onoff_pkg::CMD_CLEAR, 8'h00, 1'b0);
    check({alert, status}, 7'h42);
    flt = 4'h1;
    cyc(2);
    flt = 4'h0;
    pin = 1'b0;
    cyc(1);
    pin = 1'b1;
    cyc(6);
    check(status[0], 1'b1);
    pin = 1'b0;
    cyc(4);
    pin = 1'b1;
    cyc(6);
    check(status, 6'h00);
    ce = 1'b0;
    flt = 4'h1;
    cyc(4);
    check(status, 6'h00);
    ce = 1'b1;
    cyc(3);
    check(status[0], 1'b1);
    flt = 4'h0;
    ov_pulse();
    check({low_sw, run}, 2'b10);
    fb_low = 1'b1;
    cyc(8);
    check(low_sw, 1'b1);
    wr(onoff_pkg::CMD_CLEAR, 8'h00, 1'b0);
    check({low_sw, run}, 2'b00);
    {fb_low, rel} = 2'b01;
    cyc(4);
    ov_pulse();
    check(low_sw, 1'b1);
    fb_low = 1'b1;
    cyc(6);
    check(low_sw, 1'b0);
    {fb_low, rel, pin} = 3'b000;
    cyc(6);
    pin = 1'b1;
    cyc(6);
    check(run, 1'b1);
    wr(onoff_pkg::CMD_GUARD, onoff_pkg::GUARD_ALL, 1'b0);
    wr(onoff_pkg::CMD_ONOFF, 8'h00, 1'b1);
    check(status[5], 1'b1);
    rd(onoff_pkg::CMD_ONOFF, 8'h15, 1'b0);
    restore = 1'b1;
    cyc(1);
    restore = 1'b0;
    cyc(3);
    check(cfg, 5'h15);
    wr(onoff_pkg::CMD_GUARD, onoff_pkg::GUARD_OPER, 1'b0);
    wr(onoff_pkg::CMD_ONOFF, 8'h00, 1'b1);
    wr(onoff_pkg::CMD_GUARD, onoff_pkg::GUARD_CFG, 1'b0);
    wr(onoff_pkg::CMD_ONOFF, 8'h1D, 1'b0);
    rd(onoff_pkg::CMD_ONOFF, 8'h1D, 1'b0);
    wr(onoff_pkg::CMD_GUARD, 8'h00, 1'b0);
    wr(onoff_pkg::CMD_CLEAR, 8'h00, 1'b0);
    check(status[5], 1'b0);
    wr(onoff_pkg::CMD_GUARD, 8'hE0, 1'b0);
    check({alert, status[5]}, 2'b11);
    wr(onoff_pkg::CMD_ONOFF, 8'h16, 1'b0);
    wr(onoff_pkg::CMD_GUARD, 8'h00, 1'b0);
    wr(onoff_pkg::CMD_STORE, 8'h00, 1'b0);
    check(stores, 1);
    check(simg, {5'h16, 8'h00});
    give_verdict();
  end
endmodule // power_switch_ctrl_tb
`default_nettype wire
